// ---- logic/pmcc_pkg.sv ----
// Package for the power module configuration command bank.
// Assumes one 125 MHz clock and a command port that carries decoded PMBus codes.
package pmcc_pkg;

  // Command codes of the configuration commands
  localparam logic [7:0] CMD_BUS_CFG    = 8'hc9;
  localparam logic [7:0] CMD_OK_RISE    = 8'hd7;
  localparam logic [7:0] CMD_OK_FALL    = 8'hd8;
  localparam logic [7:0] CMD_THERM_SEL  = 8'hdc;
  localparam logic [7:0] CMD_IOUT_GAIN  = 8'hea;
  localparam logic [7:0] CMD_MIN_PULSE  = 8'heb;

  // Field positions inside the bus configuration word
  localparam int BUS_OK_POL_BIT   = 39;
  localparam int BUS_CTL_POL_BIT  = 32;
  localparam int BUS_BASE_MSB     = 31;
  localparam int BUS_BASE_LSB     = 24;
  localparam int BUS_OFS_MSB      = 23;
  localparam int BUS_OFS_LSB      = 17;
  localparam int BUS_RES_EN_BIT   = 16;

  // Field positions inside the sensor routing byte
  localparam int THERM_FLT_MSB    = 4;
  localparam int THERM_FLT_LSB    = 3;
  localparam int THERM_RB_MSB     = 2;
  localparam int THERM_RB_LSB     = 0;

  // Reset values
  localparam logic [7:0]  RST_BASE      = 8'h40;
  localparam logic [6:0]  RST_OFS       = 7'h00;
  localparam logic        RST_RES_EN    = 1'b0;
  localparam logic        RST_OK_POL    = 1'b1;
  localparam logic        RST_CTL_POL   = 1'b0;
  localparam logic [15:0] RST_OK_RISE   = 16'h0000;
  localparam logic [15:0] RST_OK_FALL   = 16'h0000;
  localparam logic [1:0]  RST_THERM_FLT = 2'h2;
  localparam logic [2:0]  RST_THERM_RB  = 3'h0;
  localparam logic [15:0] RST_IOUT_GAIN = 16'h0000;
  localparam logic [7:0]  RST_MIN_PULSE = 8'h00;

  // Fault sensor codes
  localparam logic [1:0] SENS_EXT_ONE = 2'h0;
  localparam logic [1:0] SENS_EXT_TWO = 2'h1;
  localparam logic [1:0] SENS_INTERN  = 2'h2;

  // Stored configuration
  typedef struct packed {
    logic        ok_active_high;
    logic        ctl_active_high;
    logic [7:0]  addr_base;
    logic [6:0]  addr_ofs;
    logic        ofs_from_resistor;
    logic [15:0] ok_rise;
    logic [15:0] ok_fall;
    logic [1:0]  therm_fault_src;
    logic [2:0]  therm_readback;
    logic [15:0] iout_gain;
    logic [7:0]  min_pulse;
  } pmcc_cfg_t;

  // One command request
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  code;
    logic [39:0] wdata;
  } pmcc_cmd_t;

  // One command answer
  typedef struct packed {
    logic        valid;
    logic        nack;
    logic [39:0] rdata;
  } pmcc_ans_t;

endpackage

// ---- logic/pmcc_okgate.sv ----
// Output-ok comparator with separate rise and fall thresholds.
// Assumes the output voltage sample is synchronous, same scale as thresholds.
`timescale 1ns/1ps
module pmcc_okgate (
  input  wire logic        clock_i,
  input  wire logic        rst_i,
  input  wire logic [15:0] vout_i,
  input  wire logic [15:0] rise_thr_i,
  input  wire logic [15:0] fall_thr_i,
  input  wire logic        active_high_i,
  output logic             ok_o,
  output logic             ok_pin_o
);

  typedef struct packed {
    logic ok;
    logic pin;
  } pmcc_ok_st_t;

  pmcc_ok_st_t st_q, st_d;

  // Hysteresis: set at the rise level, clear at the fall level
  always_comb begin
    st_d = st_q;
    if (!st_q.ok && vout_i >= rise_thr_i) begin
      st_d.ok = 1'b1;
    end else if (st_q.ok && vout_i <= fall_thr_i) begin
      st_d.ok = 1'b0;
    end
    st_d.pin = active_high_i ? st_d.ok : ~st_d.ok;
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      st_q <= '{ok: 1'b0, pin: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  assign ok_o     = st_q.ok;
  assign ok_pin_o = st_q.pin;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  a_ok_rises: assert property (!ok_o && vout_i >= rise_thr_i |=> ok_o)
    else $error("output ok did not rise at threshold");
  a_ok_falls: assert property (ok_o && vout_i <= fall_thr_i |=> !ok_o)
    else $error("output ok did not fall at threshold");
  a_ok_holds: assert property (ok_o && vout_i > fall_thr_i |=> ok_o)
    else $error("output ok dropped above fall threshold");
  a_pin_polarity: assert property (##1 ok_pin_o == ($past(active_high_i) ? ok_o : !ok_o))
    else $error("output ok pin polarity wrong");
  c_ok_cycle: cover property (!ok_o ##1 ok_o [*2] ##1 !ok_o);

endmodule // pmcc_okgate

// ---- logic/pmcc_bank.sv ----
// Configuration command bank of a digital power converter controller.
// Assumes a PMBus front end that decodes frames into one-cycle command strobes.
//
// Functional notes
// - Address base from config bits 31:24.
// - Field offset bits 23:17 added when resistor off.
// - Bit 16 picks field or resistor offset.
// - Output ok rises at rise threshold.
// - Output ok falls at fall threshold.
// - Bits 4:3 pick fault temperature sensor.
// - Bits 2:0 pick ordered readback sensor pair.
// - Hold 16-bit Linear11 output current gain.
// - Hold 8-bit minimum drive pulse width.
`timescale 1ns/1ps
module pmcc_bank (
  input  wire logic                clock_i,
  input  wire logic                rst_i,
  input  wire pmcc_pkg::pmcc_cmd_t cmd_i,
  output pmcc_pkg::pmcc_ans_t      ans_o,
  input  wire logic [3:0]          address_strap_one_i,
  input  wire logic [3:0]          address_strap_two_i,
  input  wire logic [15:0]         vout_i,
  output logic [7:0]               bus_address_o,
  output logic                     ctl_active_high_o,
  output logic                     output_ok_signal_o,
  output logic [1:0]               therm_fault_src_o,
  output logic [1:0]               therm_read_one_o,
  output logic [1:0]               therm_read_two_o,
  output logic [15:0]              output_current_gain_o,
  output logic [7:0]               shortest_drive_pulse_o
);

  typedef struct packed {
    pmcc_pkg::pmcc_cfg_t cfg;
    pmcc_pkg::pmcc_ans_t ans;
    logic [7:0]          addr;
    logic [1:0]          rd_one;
    logic [1:0]          rd_two;
  } pmcc_bank_st_t;

  localparam pmcc_pkg::pmcc_cfg_t CFG_RST = '{
    ok_active_high:    pmcc_pkg::RST_OK_POL,
    ctl_active_high:   pmcc_pkg::RST_CTL_POL,
    addr_base:         pmcc_pkg::RST_BASE,
    addr_ofs:          pmcc_pkg::RST_OFS,
    ofs_from_resistor: pmcc_pkg::RST_RES_EN,
    ok_rise:           pmcc_pkg::RST_OK_RISE,
    ok_fall:           pmcc_pkg::RST_OK_FALL,
    therm_fault_src:   pmcc_pkg::RST_THERM_FLT,
    therm_readback:    pmcc_pkg::RST_THERM_RB,
    iout_gain:         pmcc_pkg::RST_IOUT_GAIN,
    min_pulse:         pmcc_pkg::RST_MIN_PULSE
  };

  // Readback sensor codes: 0 external one, 1 external two, 2 internal
  localparam logic [1:0] RB_A = pmcc_pkg::SENS_EXT_ONE;
  localparam logic [1:0] RB_B = pmcc_pkg::SENS_EXT_TWO;
  localparam logic [1:0] RB_I = pmcc_pkg::SENS_INTERN;

  pmcc_bank_st_t st_q, st_d;
  logic [6:0]    strap_ofs;
  logic [6:0]    eff_ofs;
  logic          ok_level;
  logic [39:0]   rd_word;
  logic          hit;

  // Resistor-derived offset: strap two gives upper bits, strap one lower
  assign strap_ofs = {address_strap_two_i[2:0], address_strap_one_i};

  // Offset source follows the stored selector
  assign eff_ofs = st_q.cfg.ofs_from_resistor ? strap_ofs : st_q.cfg.addr_ofs;

  // Read mux and code decode
  always_comb begin
    rd_word = '0;
    hit     = 1'b1;
    unique case (cmd_i.code)
      pmcc_pkg::CMD_BUS_CFG: begin
        rd_word[pmcc_pkg::BUS_OK_POL_BIT]                      = st_q.cfg.ok_active_high;
        rd_word[pmcc_pkg::BUS_CTL_POL_BIT]                     = st_q.cfg.ctl_active_high;
        rd_word[pmcc_pkg::BUS_BASE_MSB:pmcc_pkg::BUS_BASE_LSB] = st_q.cfg.addr_base;
        rd_word[pmcc_pkg::BUS_OFS_MSB:pmcc_pkg::BUS_OFS_LSB]   = st_q.cfg.addr_ofs;
        rd_word[pmcc_pkg::BUS_RES_EN_BIT]                      = st_q.cfg.ofs_from_resistor;
      end
      pmcc_pkg::CMD_OK_RISE:   rd_word[15:0] = st_q.cfg.ok_rise;
      pmcc_pkg::CMD_OK_FALL:   rd_word[15:0] = st_q.cfg.ok_fall;
      pmcc_pkg::CMD_THERM_SEL: begin
        rd_word[pmcc_pkg::THERM_FLT_MSB:pmcc_pkg::THERM_FLT_LSB] = st_q.cfg.therm_fault_src;
        rd_word[pmcc_pkg::THERM_RB_MSB:pmcc_pkg::THERM_RB_LSB]   = st_q.cfg.therm_readback;
      end
      pmcc_pkg::CMD_IOUT_GAIN: rd_word[15:0] = st_q.cfg.iout_gain;
      pmcc_pkg::CMD_MIN_PULSE: rd_word[7:0]  = st_q.cfg.min_pulse;
      default:                 hit = 1'b0;
    endcase
  end

  // Next state: writes, answers, derived address and readback pair
  always_comb begin
    st_d           = st_q;
    st_d.ans       = '0;
    if (cmd_i.wr && hit) begin
      unique case (cmd_i.code)
        pmcc_pkg::CMD_BUS_CFG: begin
          st_d.cfg.ok_active_high    = cmd_i.wdata[pmcc_pkg::BUS_OK_POL_BIT];
          st_d.cfg.ctl_active_high   = cmd_i.wdata[pmcc_pkg::BUS_CTL_POL_BIT];
          st_d.cfg.addr_base         = cmd_i.wdata[pmcc_pkg::BUS_BASE_MSB:pmcc_pkg::BUS_BASE_LSB];
          st_d.cfg.addr_ofs          = cmd_i.wdata[pmcc_pkg::BUS_OFS_MSB:pmcc_pkg::BUS_OFS_LSB];
          st_d.cfg.ofs_from_resistor = cmd_i.wdata[pmcc_pkg::BUS_RES_EN_BIT];
        end
        pmcc_pkg::CMD_OK_RISE:   st_d.cfg.ok_rise = cmd_i.wdata[15:0];
        pmcc_pkg::CMD_OK_FALL:   st_d.cfg.ok_fall = cmd_i.wdata[15:0];
        pmcc_pkg::CMD_THERM_SEL: begin
          st_d.cfg.therm_fault_src = cmd_i.wdata[pmcc_pkg::THERM_FLT_MSB:pmcc_pkg::THERM_FLT_LSB];
          st_d.cfg.therm_readback  = cmd_i.wdata[pmcc_pkg::THERM_RB_MSB:pmcc_pkg::THERM_RB_LSB];
        end
        pmcc_pkg::CMD_IOUT_GAIN: st_d.cfg.iout_gain = cmd_i.wdata[15:0];
        pmcc_pkg::CMD_MIN_PULSE: st_d.cfg.min_pulse = cmd_i.wdata[7:0];
        default:                 st_d.cfg = st_q.cfg;
      endcase
    end
    // Every strobe gets one answer; unknown codes are refused
    if (cmd_i.wr || cmd_i.rd) begin
      st_d.ans.valid = 1'b1;
      st_d.ans.nack  = ~hit;
      st_d.ans.rdata = cmd_i.rd ? rd_word : '0;
    end
    // Address is base plus chosen offset, modulo 256
    st_d.addr = 8'(st_q.cfg.addr_base + {1'b0, eff_ofs});
    // Ordered readback pair; reserved codes fall back to the first pair
    unique case (st_q.cfg.therm_readback)
      3'h1:    {st_d.rd_one, st_d.rd_two} = {RB_A, RB_I};
      3'h2:    {st_d.rd_one, st_d.rd_two} = {RB_B, RB_A};
      3'h3:    {st_d.rd_one, st_d.rd_two} = {RB_B, RB_I};
      3'h4:    {st_d.rd_one, st_d.rd_two} = {RB_I, RB_A};
      3'h5:    {st_d.rd_one, st_d.rd_two} = {RB_I, RB_B};
      default: {st_d.rd_one, st_d.rd_two} = {RB_A, RB_B};
    endcase
  end

  // State register
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      st_q <= '{cfg: CFG_RST, ans: '0, addr: '0, rd_one: RB_A, rd_two: RB_B};
    end else begin
      st_q <= st_d;
    end
  end

  // Output ok comparator with polarity control
  pmcc_okgate u_okgate (
    .clock_i       (clock_i),
    .rst_i         (rst_i),
    .vout_i        (vout_i),
    .rise_thr_i    (st_q.cfg.ok_rise),
    .fall_thr_i    (st_q.cfg.ok_fall),
    .active_high_i (st_q.cfg.ok_active_high),
    .ok_o          (ok_level),
    .ok_pin_o      (output_ok_signal_o)
  );

  // Outputs from the state register
  assign ans_o                  = st_q.ans;
  assign bus_address_o          = st_q.addr;
  assign ctl_active_high_o      = st_q.cfg.ctl_active_high;
  assign therm_fault_src_o      = st_q.cfg.therm_fault_src;
  assign therm_read_one_o       = st_q.rd_one;
  assign therm_read_two_o       = st_q.rd_two;
  assign output_current_gain_o  = st_q.cfg.iout_gain;
  assign shortest_drive_pulse_o = st_q.cfg.min_pulse;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  a_addr_field: assert property (!st_q.cfg.ofs_from_resistor ##1 1'b1 |->
      bus_address_o == 8'($past(st_q.cfg.addr_base) + {1'b0, $past(st_q.cfg.addr_ofs)}))
    else $error("field offset address wrong");
  a_addr_strap: assert property (st_q.cfg.ofs_from_resistor ##1 1'b1 |->
      bus_address_o == 8'($past(st_q.cfg.addr_base) + {1'b0, $past(strap_ofs)}))
    else $error("resistor offset address wrong");
  a_base_write: assert property (cmd_i.wr && cmd_i.code == pmcc_pkg::CMD_BUS_CFG |=>
      st_q.cfg.addr_base == $past(cmd_i.wdata[31:24]))
    else $error("address base not stored");
  a_fault_sel: assert property (cmd_i.wr && cmd_i.code == pmcc_pkg::CMD_THERM_SEL |=>
      therm_fault_src_o == $past(cmd_i.wdata[4:3]))
    else $error("fault sensor select not stored");
  a_pair_map: assert property (cmd_i.wr && cmd_i.code == pmcc_pkg::CMD_THERM_SEL && cmd_i.wdata[2:0] == 3'h3
      |=> ##1 therm_read_one_o == RB_B && therm_read_two_o == RB_I)
    else $error("readback pair mapping wrong");
  a_gain_hold: assert property (cmd_i.wr && cmd_i.code == pmcc_pkg::CMD_IOUT_GAIN |=>
      output_current_gain_o == $past(cmd_i.wdata[15:0]))
    else $error("current gain not stored");
  a_pulse_hold: assert property (!(cmd_i.wr && cmd_i.code == pmcc_pkg::CMD_MIN_PULSE) |=>
      shortest_drive_pulse_o == $past(shortest_drive_pulse_o))
    else $error("minimum pulse changed without write");
  a_ok_tracks: assert property ($rose(ok_level) |-> $past(vout_i) >= $past(st_q.cfg.ok_rise))
    else $error("output ok rose below threshold");
  a_ok_drops: assert property ($fell(ok_level) |-> $past(vout_i) <= $past(st_q.cfg.ok_fall))
    else $error("output ok fell above threshold");
  a_answer_once: assert property (cmd_i.rd || cmd_i.wr |=> ans_o.valid ##1 !ans_o.valid || $past(cmd_i.rd || cmd_i.wr))
    else $error("answer not a single pulse");

  c_read_cfg: cover property (cmd_i.rd && cmd_i.code == pmcc_pkg::CMD_BUS_CFG ##1 ans_o.valid);
  c_strap_addr: cover property (st_q.cfg.ofs_from_resistor && bus_address_o != st_q.cfg.addr_base);
  c_nack: cover property (ans_o.valid && ans_o.nack);
  c_ok_rise: cover property ($rose(ok_level));

endmodule // pmcc_bank

// ---- dv/pmcc_host.sv ----
// Host model that issues configuration commands into the command bank.
// Assumes the bench calls access() from one thread, one command at a time.
`timescale 1ns/1ps
module pmcc_host (
  input  wire logic                clock_i,
  output pmcc_pkg::pmcc_cmd_t      cmd_o,
  input  wire pmcc_pkg::pmcc_ans_t ans_i
);
  initial cmd_o = '0;

  // Strobe one command for a cycle, then wait a bounded time for the answer
  task automatic access(input logic wr, input logic [7:0] code, input logic [39:0] wdata,
                        output logic [39:0] rdata, output logic nack);
    int n;
    n = 0;
    @(posedge clock_i);
    cmd_o <= '{wr: wr, rd: ~wr, code: code, wdata: wdata};
    @(posedge clock_i);
    cmd_o <= '{wr: 1'b0, rd: 1'b0, code: ~code, wdata: ~wdata}; // Idle fields scrambled
    #1;
    while (ans_i.valid !== 1'b1 && n < 4) begin
      @(posedge clock_i);
      #1;
      n++;
    end
    rdata = (n < 4) ? ans_i.rdata : 'x;
    nack  = (n < 4) ? ans_i.nack : 1'bx;
  endtask
endmodule // pmcc_host

// ---- dv/test_power_module_config_commands.sv ----
// Self-checking bench for the configuration command bank.
// Assumes the host model in pmcc_host and one 125 MHz clock.
`timescale 1ns/1ps
module test_power_module_config_commands;
  logic                clock_i = 1'b0;
  logic                rst_i   = 1'b1;
  pmcc_pkg::pmcc_cmd_t cmd;
  pmcc_pkg::pmcc_ans_t ans;
  logic [3:0]          so      = 4'h3;
  logic [3:0]          st      = 4'h2;
  logic [15:0]         vout    = 16'h0001; // Above the reset fall threshold, so ok settles high
  logic [7:0]          addr;
  logic                ctl;
  logic                okp;
  logic [1:0]          fsrc;
  logic [1:0]          r1;
  logic [1:0]          r2;
  logic [15:0]         gain;
  logic [7:0]          pulse;
  logic [39:0]         rd;
  logic                nk;
  logic [39:0]         cfg;
  int                  errors    = 0;
  int                  cmp_count = 0;
  logic [39:0] acfg [5] = '{40'h01_200a_0000, 40'h00_200b_0000, 40'h00_f0fe_0000, 40'hff_ffff_ffff, 40'hff_ffff_ffff};
  logic [3:0]  aso  [5] = '{4'h3, 4'h3, 4'h3, 4'h3, 4'hf};
  logic [3:0]  ast  [5] = '{4'h2, 4'h2, 4'h2, 4'h2, 4'h7};
  logic [3:0]  pair [6] = '{4'h1, 4'h2, 4'h4, 4'h6, 4'h8, 4'h9};
  logic [15:0] vt   [7] = '{16'h0000, 16'h0c00, 16'h1000, 16'h0c00, 16'h0801, 16'h0800, 16'h0fff};
  logic        okt  [7] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};

  pmcc_host i_host (.clock_i(clock_i), .cmd_o(cmd), .ans_i(ans));

  pmcc_bank i_dut (
    .clock_i(clock_i), .rst_i(rst_i), .cmd_i(cmd), .ans_o(ans),
    .address_strap_one_i(so), .address_strap_two_i(st), .vout_i(vout),
    .bus_address_o(addr), .ctl_active_high_o(ctl), .output_ok_signal_o(okp),
    .therm_fault_src_o(fsrc), .therm_read_one_o(r1), .therm_read_two_o(r2),
    .output_current_gain_o(gain), .shortest_drive_pulse_o(pulse)
  );

  // Clock at 8 ns
  always #4 clock_i = ~clock_i;

  task automatic check(input string what, input logic [39:0] seen, input logic [39:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] code, input logic [39:0] d);
    i_host.access(1'b1, code, d, rd, nk);
  endtask

  task automatic rchk(input logic [7:0] code, input logic [39:0] exp);
    i_host.access(1'b0, code, 40'h0, rd, nk);
    check("readback", rd, exp);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask

  task automatic print_verdict();
    if (errors == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Watchdog against a hung handshake
  initial begin
    #400000;
    errors++;
    print_verdict();
  end

  // Main sequence
  initial begin
    repeat (16) @(posedge clock_i);
    rst_i <= 1'b0;
    cyc(2);
    // Values after reset
    check("bus_address", addr, 40'h40);
    check("fault_src", fsrc, 40'h2);
    check("read_pair", {r1, r2}, 40'h1);
    check("ok_pin", okp, 40'h1);
    rchk(pmcc_pkg::CMD_BUS_CFG, 40'h80_4000_0000);
    rchk(pmcc_pkg::CMD_OK_RISE, 40'h0);
    rchk(pmcc_pkg::CMD_OK_FALL, 40'h0);
    rchk(pmcc_pkg::CMD_THERM_SEL, 40'h10);
    rchk(pmcc_pkg::CMD_IOUT_GAIN, 40'h0);
    rchk(pmcc_pkg::CMD_MIN_PULSE, 40'h0);
    // Address from field or strap, with wrap; control polarity checked, polarity bits read back
    for (int i = 0; i < 5; i++) begin
      @(posedge clock_i);
      so <= aso[i];
      st <= ast[i];
      cfg = acfg[i];
      wr(pmcc_pkg::CMD_BUS_CFG, cfg);
      cyc(2);
      check("bus_address", addr, 8'(cfg[31:24] + (cfg[16] ? {st[2:0], so} : cfg[23:17])));
      check("ctl_pol", ctl, cfg[32]);
      rchk(pmcc_pkg::CMD_BUS_CFG, cfg & 40'h81_ffff_0000);
    end
    // Every defined sensor code, unused bits set; reserved codes never sent
    for (int f = 0; f < 3; f++) begin
      for (int r = 0; r < 6; r++) begin
        wr(pmcc_pkg::CMD_THERM_SEL, 40'hff_ffff_ffe0 | {f[1:0], r[2:0]});
        cyc(2);
        check("fault_src", fsrc, f);
        check("read_pair", {r1, r2}, pair[r]);
        rchk(pmcc_pkg::CMD_THERM_SEL, {f[1:0], r[2:0]});
      end
    end
    // Output ok with hysteresis between thresholds
    wr(pmcc_pkg::CMD_BUS_CFG, 40'h80_4000_0000);
    wr(pmcc_pkg::CMD_OK_RISE, 40'hff_ffff_1000);
    rchk(pmcc_pkg::CMD_OK_RISE, 40'h1000);
    wr(pmcc_pkg::CMD_OK_FALL, 40'hff_ffff_0800);
    rchk(pmcc_pkg::CMD_OK_FALL, 40'h0800);
    for (int i = 0; i < 7; i++) begin
      @(posedge clock_i);
      vout <= vt[i];
      cyc(3);
      check("ok_pin", okp, okt[i]);
    end
    // Active-low polarity inverts the pin
    wr(pmcc_pkg::CMD_BUS_CFG, 40'h00_4000_0000);
    cyc(3);
    check("ok_pin", okp, 40'h1);
    // Gain and pulse width, unused bits ignored
    wr(pmcc_pkg::CMD_IOUT_GAIN, 40'hff_ffff_a5c3);
    cyc(1);
    check("gain", gain, 40'ha5c3);
    rchk(pmcc_pkg::CMD_IOUT_GAIN, 40'ha5c3);
    wr(pmcc_pkg::CMD_MIN_PULSE, 40'hff_ffff_ff7e);
    cyc(1);
    check("pulse", pulse, 40'h7e);
    rchk(pmcc_pkg::CMD_MIN_PULSE, 40'h7e);
    // Unknown code refused without side effects
    i_host.access(1'b1, 8'hec, 40'hff_ffff_ffff, rd, nk);
    check("nack", nk, 40'h1);
    check("nack_data", rd, 40'h0);
    rchk(pmcc_pkg::CMD_MIN_PULSE, 40'h7e);
    // Reset in mid-run restores the address
    @(posedge clock_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    rst_i <= 1'b0;
    cyc(3);
    check("bus_address", addr, 40'h40);
    check("gain", gain, 40'h0);
    print_verdict();
  end
endmodule // test_power_module_config_commands
